// ==== effective_address_decoder.sv ====
// Local design decisions: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module effective_address_decoder (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic [5:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest
);

    ////////////////////////////////////////////////////////////////////////////

    typedef struct packed {
        ea_decode_pkg::bus_state_t bus_state;
        logic [4:0] code;
        ea_decode_pkg::op_width_t width;
        logic var_len;
        logic [3:0] base_len;
        logic [7:0] base_cyc;
        ea_decode_pkg::access_class_t place;
        logic odd;
        logic [7:0] imm8;
        logic [15:0] acc_lo;
        logic [15:0] acc_hi;
        logic flag_n;
        logic flag_z;
        logic [31:0] rdata;
    } state_t;

    state_t st_reg;
    state_t st_next;
    ea_decode_pkg::ea_info_t info;
    ea_decode_pkg::access_class_t eff_place;
    logic [2:0] corr;
    logic [4:0] total_len;
    logic [9:0] total_cyc;
    logic [2:0] reg_sel;
    logic [15:0] imm_sx;
    logic [31:0] old_word;
    logic [31:0] new_word;
    logic accept;

    ////////////////////////////////////////////////////////////////////////////

    function automatic ea_decode_pkg::ea_info_t decode_ea(input logic [4:0] code);
        ea_decode_pkg::ea_info_t r;
        r = '0;
        if (code <= ea_decode_pkg::EA_REG_LAST)
        begin
            r.is_reg = 1'b1;
        end
        else
        begin
            r.is_mem = 1'b1;
            r.base_reg = {1'b0, code[1:0]};
            if (code < ea_decode_pkg::EA_POSTINC_FIRST)
                r.cyc = ea_decode_pkg::CYC_IND;
            else if (code < ea_decode_pkg::EA_SHORT_DISPLACEMENT_FIRST)
            begin
                r.post_inc = 1'b1;
                r.cyc = ea_decode_pkg::CYC_POSTINC;
            end
            else if (code < ea_decode_pkg::EA_LONG_DISPLACEMENT_FIRST)
            begin
                r.base_reg = code[2:0];
                r.ext = ea_decode_pkg::EXT_ONE;
                r.cyc = ea_decode_pkg::CYC_SHORT_DISPLACEMENT;
            end
            else if (code < ea_decode_pkg::EA_INDEX_R0)
            begin
                r.ext = ea_decode_pkg::EXT_TWO;
                r.cyc = ea_decode_pkg::CYC_LONG_DISPLACEMENT;
            end
            else if (code == ea_decode_pkg::EA_INDEX_R0 || code == ea_decode_pkg::EA_INDEX_R1)
            begin
                r.index7 = 1'b1;
                r.cyc = ea_decode_pkg::CYC_INDEX;
            end
            else if (code == ea_decode_pkg::EA_PC_DISP)
            begin
                r.base_reg = '0;
                r.pc_rel = 1'b1;
                r.ext = ea_decode_pkg::EXT_TWO;
                r.cyc = ea_decode_pkg::CYC_PC;
            end
            else
            begin
                r.base_reg = '0;
                r.direct = 1'b1;
                r.ext = ea_decode_pkg::EXT_TWO;
                r.cyc = ea_decode_pkg::CYC_DIRECT;
            end
        end
        return r;
    endfunction

    function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
            if (be[i])
                r[i*8 +: 8] = wd[i*8 +: 8];
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////

    assign info = decode_ea(st_reg.code);
    // A register operand never touches memory, whatever place was configured.
    assign eff_place = info.is_reg ? ea_decode_pkg::ACC_REG : st_reg.place;
    // Long registers pair up, so two codes share one long register.
    assign reg_sel = (st_reg.width == ea_decode_pkg::W_LONG) ? {1'b0, st_reg.code[2:1]}
                                                              : st_reg.code[2:0];
    assign total_len = st_reg.var_len ? {1'b0, st_reg.base_len} + {3'b000, info.ext}
                                      : {1'b0, st_reg.base_len};
    assign total_cyc = {2'b00, st_reg.base_cyc} + {7'h00, info.cyc} + {7'h00, corr};
    assign imm_sx = {{8{st_reg.imm8[7]}}, st_reg.imm8};
    assign waitrequest = (read || write) && st_reg.bus_state != ea_decode_pkg::ST_ACK;
    assign accept = write && st_reg.bus_state == ea_decode_pkg::ST_ACK;
    assign readdata = st_reg.rdata;

    cycle_correction u_corr (
        .width(st_reg.width),
        .place(eff_place),
        .odd(st_reg.odd),
        .extra(corr)
    );

    ////////////////////////////////////////////////////////////////////////////

    always_comb
    begin
        old_word = ea_decode_pkg::READ_NONE;
        unique case (address)
            ea_decode_pkg::OFS_DECODE:
            begin
                old_word[ea_decode_pkg::DEC_CODE_LSB +: 5] = st_reg.code;
                old_word[ea_decode_pkg::DEC_WIDTH_LSB +: 2] = st_reg.width;
                old_word[ea_decode_pkg::DEC_VAR_BIT] = st_reg.var_len;
                old_word[ea_decode_pkg::DEC_LEN_LSB +: 4] = st_reg.base_len;
                old_word[ea_decode_pkg::DEC_CYC_LSB +: 8] = st_reg.base_cyc;
            end
            ea_decode_pkg::OFS_ACCESS:
            begin
                old_word[ea_decode_pkg::ACS_CLASS_LSB +: 2] = st_reg.place;
                old_word[ea_decode_pkg::ACS_ODD_BIT] = st_reg.odd;
            end
            ea_decode_pkg::OFS_STATUS:
                old_word = {13'h0000, st_reg.width, reg_sel, info};
            ea_decode_pkg::OFS_TOTAL:
                old_word = {14'h0000, total_cyc, 3'h0, total_len};
            ea_decode_pkg::OFS_IMM:
                old_word = {imm_sx, 8'h00, st_reg.imm8};
            ea_decode_pkg::OFS_VECTOR:
                old_word = {16'h0000, st_reg.imm8, 4'h0, st_reg.imm8[3:0]};
            ea_decode_pkg::OFS_LOAD:
            begin
                old_word[ea_decode_pkg::FLAG_N_BIT] = st_reg.flag_n;
                old_word[ea_decode_pkg::FLAG_Z_BIT] = st_reg.flag_z;
            end
            ea_decode_pkg::OFS_ACC_LO:
                old_word = {16'h0000, st_reg.acc_lo};
            ea_decode_pkg::OFS_ACC_HI:
                old_word = {16'h0000, st_reg.acc_hi};
            default:
                old_word = ea_decode_pkg::READ_NONE;
        endcase
    end

    assign new_word = merge_bytes(old_word, writedata, byteenable);

    always_comb
    begin
        st_next = st_reg;
        unique case (st_reg.bus_state)
            ea_decode_pkg::ST_IDLE:
            begin
                if (read || write)
                    st_next.bus_state = ea_decode_pkg::ST_ACK;
                // Read data is sampled one cycle early so it comes from a flop.
                if (read)
                    st_next.rdata = old_word;
            end
            ea_decode_pkg::ST_ACK:
                st_next.bus_state = ea_decode_pkg::ST_IDLE;
            default:
                st_next.bus_state = ea_decode_pkg::ST_IDLE;
        endcase
        if (accept)
        begin
            unique case (address)
                ea_decode_pkg::OFS_DECODE:
                begin
                    st_next.code = new_word[ea_decode_pkg::DEC_CODE_LSB +: 5];
                    st_next.width = ea_decode_pkg::op_width_t'(new_word[ea_decode_pkg::DEC_WIDTH_LSB +: 2]);
                    st_next.var_len = new_word[ea_decode_pkg::DEC_VAR_BIT];
                    st_next.base_len = new_word[ea_decode_pkg::DEC_LEN_LSB +: 4];
                    st_next.base_cyc = new_word[ea_decode_pkg::DEC_CYC_LSB +: 8];
                end
                ea_decode_pkg::OFS_ACCESS:
                begin
                    st_next.place = ea_decode_pkg::access_class_t'(new_word[ea_decode_pkg::ACS_CLASS_LSB +: 2]);
                    st_next.odd = new_word[ea_decode_pkg::ACS_ODD_BIT];
                end
                ea_decode_pkg::OFS_IMM:
                    st_next.imm8 = new_word[7:0];
                ea_decode_pkg::OFS_LOAD:
                begin
                    if (new_word[ea_decode_pkg::LOAD_PUSH_BIT])
                        st_next.acc_hi = st_reg.acc_lo;
                    if (new_word[ea_decode_pkg::LOAD_SX_BIT])
                        st_next.acc_lo = {{8{new_word[7]}}, new_word[7:0]};
                    else
                        st_next.acc_lo = {ea_decode_pkg::ZERO_BYTE, new_word[7:0]};
                    // Sign and zero follow the byte; other flags are not held here.
                    st_next.flag_n = new_word[7];
                    st_next.flag_z = new_word[7:0] == ea_decode_pkg::ZERO_BYTE;
                end
                default:
                    st_next.bus_state = ea_decode_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            st_reg <= '0;
            st_reg.acc_lo <= ea_decode_pkg::ACC_RESET;
            st_reg.acc_hi <= ea_decode_pkg::ACC_RESET;
        end
        else
            st_reg <= st_next;
    end

    ////////////////////////////////////////////////////////////////////////////

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (srst);

    sequence s_load_accept;
        accept && address == ea_decode_pkg::OFS_LOAD && byteenable == 4'hF;
    endsequence

    sequence s_sx_load;
        s_load_accept ##0 writedata[ea_decode_pkg::LOAD_SX_BIT];
    endsequence

    a_reg_direct: assert property (st_reg.code <= 5'h07 |-> info.is_reg && !info.is_mem && total_cyc == {2'b00, st_reg.base_cyc})
        else $error("register code decoded as memory");
    a_mem_form: assert property (st_reg.code > 5'h07 |-> info.is_mem && !info.is_reg && info.cyc != 3'h0)
        else $error("memory code decoded as register");
    a_post_inc: assert property (st_reg.code inside {[5'h0C:5'h0F]} |-> info.post_inc && info.ext == 2'h0 && info.cyc == 3'h4)
        else $error("post increment decode wrong");
    a_short_disp: assert property (st_reg.code inside {[5'h10:5'h17]} |-> info.ext == 2'h1 && info.cyc == 3'h1 && info.base_reg == st_reg.code[2:0])
        else $error("short displacement decode wrong");
    a_long_disp: assert property (st_reg.code inside {[5'h18:5'h1B]} |-> info.ext == 2'h2 && info.cyc == 3'h1)
        else $error("long displacement decode wrong");
    a_index_form: assert property (st_reg.code inside {5'h1C, 5'h1D} |-> info.index7 && info.ext == 2'h0 && info.cyc == 3'h2 && info.base_reg == {2'b00, st_reg.code[0]})
        else $error("index decode wrong");
    a_pc_direct: assert property (st_reg.code == 5'h1E |-> info.pc_rel && info.ext == 2'h2 && info.cyc == 3'h2)
        else $error("pc relative decode wrong");
    a_direct_addr: assert property (st_reg.code == 5'h1F |-> info.direct && info.ext == 2'h2 && info.cyc == 3'h1)
        else $error("direct decode wrong");
    a_len_add: assert property (st_reg.var_len |-> total_len == st_reg.base_len + info.ext)
        else $error("variable length not extended");
    a_even_free: assert property (eff_place == ea_decode_pkg::ACC_REG || (eff_place == ea_decode_pkg::ACC_RAM && !st_reg.odd) |-> corr == 3'h0)
        else $error("aligned internal access charged");
    a_odd_ram: assert property (eff_place == ea_decode_pkg::ACC_RAM && st_reg.odd |-> corr == (st_reg.width == ea_decode_pkg::W_LONG ? 3'h2 : st_reg.width == ea_decode_pkg::W_WORD ? 3'h1 : 3'h0))
        else $error("odd internal ram correction wrong");
    a_even_out: assert property (eff_place == ea_decode_pkg::ACC_OUTSIDE && !st_reg.odd |-> corr == (st_reg.width == ea_decode_pkg::W_LONG ? 3'h2 : 3'h1))
        else $error("even outside correction wrong");
    a_slow_path: assert property ((eff_place == ea_decode_pkg::ACC_BUS8 || (eff_place == ea_decode_pkg::ACC_OUTSIDE && st_reg.odd)) |-> corr == (st_reg.width == ea_decode_pkg::W_LONG ? 3'h6 : st_reg.width == ea_decode_pkg::W_WORD ? 3'h3 : 3'h1))
        else $error("slow path correction wrong");
    a_imm_sign: assert property (accept && address == ea_decode_pkg::OFS_IMM && byteenable[0] |=> imm_sx == {{8{$past(writedata[7])}}, $past(writedata[7:0])})
        else $error("immediate not sign extended");
    a_vector_range: assert property (read && st_reg.bus_state == ea_decode_pkg::ST_IDLE && address == ea_decode_pkg::OFS_VECTOR |=> readdata[31:16] == 16'h0000 && readdata[7:4] == 4'h0)
        else $error("vector number out of range");
    a_sx_load: assert property (s_sx_load |=> st_reg.acc_lo[15:8] == {8{$past(writedata[7])}} && st_reg.flag_n == $past(writedata[7]))
        else $error("sign extending load wrong");
    a_zx_load: assert property (s_load_accept ##0 !writedata[ea_decode_pkg::LOAD_SX_BIT] |=> st_reg.acc_lo[15:8] == 8'h00 && st_reg.flag_z == ($past(writedata[7:0]) == 8'h00))
        else $error("zero extending load wrong");
    a_push_high: assert property (s_load_accept ##0 writedata[ea_decode_pkg::LOAD_PUSH_BIT] |=> st_reg.acc_hi == $past(st_reg.acc_lo))
        else $error("high word not pushed");
    a_total_cyc: assert property (total_cyc >= {2'b00, st_reg.base_cyc} && total_cyc - {2'b00, st_reg.base_cyc} == {7'h00, info.cyc} + {7'h00, corr})
        else $error("actual cycle total wrong");
    a_bus_answer: assert property ((read || write) && st_reg.bus_state == ea_decode_pkg::ST_IDLE |-> waitrequest ##1 !waitrequest)
        else $error("bus answer late");

endmodule

`default_nettype wire

// ==== ea_decode_pkg.sv ====
// Function
// - Codes 00-07 select register by operand width.
// - Codes 08-1F are memory operand forms.
// - 0C-0F post-increment, no extension, four cycles.
// - 10-17 word register plus short displacement.
// - 18-1B word register plus long displacement.
// - 1C/1D index by register seven, two cycles.
// - 1E program counter relative, 1F direct.
// - Variable length adds extension bytes.
// - Registers and even internal RAM add nothing.
// - Odd internal RAM adds 0/1/2.
// - Even outside RAM adds 1/1/2.
// - Odd outside RAM adds 1/3/6.
// - Eight-bit external bus adds 1/3/6.
// - Short immediate sign extends to 16 bits.
// - Short vector 0-15, long vector 0-255.
// - Sign extending load fills upper byte, flags.
// - Plain byte load clears upper byte, flags.
// - Upper byte zero or sign filled first.
// - High-word loads copy low word upward first.
// - Actual cycles are base plus addressing-mode cycles plus correction.
package ea_decode_pkg;

    localparam int EA_W = 5;
    localparam logic [4:0] EA_REG_LAST = 5'h07;
    localparam logic [4:0] EA_POSTINC_FIRST = 5'h0C;
    localparam logic [4:0] EA_SHORT_DISPLACEMENT_FIRST = 5'h10;
    localparam logic [4:0] EA_LONG_DISPLACEMENT_FIRST = 5'h18;
    localparam logic [4:0] EA_INDEX_R0 = 5'h1C;
    localparam logic [4:0] EA_INDEX_R1 = 5'h1D;
    localparam logic [4:0] EA_PC_DISP = 5'h1E;
    localparam logic [4:0] EA_DIRECT = 5'h1F;
    localparam logic [2:0] INDEX_REG = 3'h7;

    localparam logic [2:0] CYC_NONE = 3'h0;
    localparam logic [2:0] CYC_IND = 3'h1;
    localparam logic [2:0] CYC_POSTINC = 3'h4;
    localparam logic [2:0] CYC_SHORT_DISPLACEMENT = 3'h1;
    localparam logic [2:0] CYC_LONG_DISPLACEMENT = 3'h1;
    localparam logic [2:0] CYC_INDEX = 3'h2;
    localparam logic [2:0] CYC_PC = 3'h2;
    localparam logic [2:0] CYC_DIRECT = 3'h1;

    localparam logic [1:0] EXT_NONE = 2'h0;
    localparam logic [1:0] EXT_ONE = 2'h1;
    localparam logic [1:0] EXT_TWO = 2'h2;

    localparam logic [2:0] COR_NONE = 3'h0;
    localparam logic [2:0] COR_ODD_RAM_WORD = 3'h1;
    localparam logic [2:0] COR_ODD_RAM_LONG = 3'h2;
    localparam logic [2:0] COR_EVEN_OUT_SHORT = 3'h1;
    localparam logic [2:0] COR_EVEN_OUT_LONG = 3'h2;
    localparam logic [2:0] COR_SLOW_BYTE = 3'h1;
    localparam logic [2:0] COR_SLOW_WORD = 3'h3;
    localparam logic [2:0] COR_SLOW_LONG = 3'h6;

    typedef enum logic [1:0] {W_BYTE = 2'h0, W_WORD = 2'h1, W_LONG = 2'h2} op_width_t;
    typedef enum logic [1:0] {ACC_REG = 2'h0, ACC_RAM = 2'h1, ACC_OUTSIDE = 2'h2, ACC_BUS8 = 2'h3} access_class_t;
    typedef enum logic [1:0] {ST_IDLE = 2'h0, ST_ACK = 2'h1} bus_state_t;

    typedef struct packed {
        logic is_reg;
        logic is_mem;
        logic post_inc;
        logic [1:0] ext;
        logic [2:0] cyc;
        logic [2:0] base_reg;
        logic index7;
        logic pc_rel;
        logic direct;
    } ea_info_t;

    localparam int ADDR_W = 6;
    localparam logic [5:0] OFS_DECODE = 6'h00;
    localparam logic [5:0] OFS_ACCESS = 6'h04;
    localparam logic [5:0] OFS_STATUS = 6'h08;
    localparam logic [5:0] OFS_TOTAL = 6'h0C;
    localparam logic [5:0] OFS_IMM = 6'h10;
    localparam logic [5:0] OFS_VECTOR = 6'h14;
    localparam logic [5:0] OFS_LOAD = 6'h18;
    localparam logic [5:0] OFS_ACC_LO = 6'h1C;
    localparam logic [5:0] OFS_ACC_HI = 6'h20;

    localparam int DEC_CODE_LSB = 0;
    localparam int DEC_WIDTH_LSB = 5;
    localparam int DEC_VAR_BIT = 7;
    localparam int DEC_LEN_LSB = 8;
    localparam int DEC_CYC_LSB = 12;
    localparam int ACS_CLASS_LSB = 0;
    localparam int ACS_ODD_BIT = 2;
    localparam int LOAD_SX_BIT = 8;
    localparam int LOAD_PUSH_BIT = 9;
    localparam int FLAG_N_BIT = 0;
    localparam int FLAG_Z_BIT = 1;
    localparam int TOT_CYC_LSB = 8;
    localparam int VEC_LONG_LSB = 8;

    localparam logic [15:0] ACC_RESET = 16'h0000;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [31:0] READ_NONE = 32'h00000000;

endpackage

`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////

// Extra bus cycles for one operand access, by place, alignment and width.
module cycle_correction (
    input wire ea_decode_pkg::op_width_t width,
    input wire ea_decode_pkg::access_class_t place,
    input wire logic odd,
    output logic [2:0] extra
);
    always_comb
    begin
        extra = ea_decode_pkg::COR_NONE;
        unique case (place)
            ea_decode_pkg::ACC_REG:
                extra = ea_decode_pkg::COR_NONE;
            ea_decode_pkg::ACC_RAM:
            begin
                if (!odd)
                    extra = ea_decode_pkg::COR_NONE;
                else if (width == ea_decode_pkg::W_WORD)
                    extra = ea_decode_pkg::COR_ODD_RAM_WORD;
                else if (width == ea_decode_pkg::W_LONG)
                    extra = ea_decode_pkg::COR_ODD_RAM_LONG;
                else
                    extra = ea_decode_pkg::COR_NONE;
            end
            ea_decode_pkg::ACC_OUTSIDE:
            begin
                if (!odd)
                    extra = (width == ea_decode_pkg::W_LONG) ? ea_decode_pkg::COR_EVEN_OUT_LONG
                                                             : ea_decode_pkg::COR_EVEN_OUT_SHORT;
                else if (width == ea_decode_pkg::W_LONG)
                    extra = ea_decode_pkg::COR_SLOW_LONG;
                else if (width == ea_decode_pkg::W_WORD)
                    extra = ea_decode_pkg::COR_SLOW_WORD;
                else
                    extra = ea_decode_pkg::COR_SLOW_BYTE;
            end
            ea_decode_pkg::ACC_BUS8:
            begin
                // A narrow bus pays the same as a misaligned outside access.
                if (width == ea_decode_pkg::W_LONG)
                    extra = ea_decode_pkg::COR_SLOW_LONG;
                else if (width == ea_decode_pkg::W_WORD)
                    extra = ea_decode_pkg::COR_SLOW_WORD;
                else
                    extra = ea_decode_pkg::COR_SLOW_BYTE;
            end
        endcase
    end
endmodule

`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_fail++; $display("mismatch %s exp %h got %h", nm, e, g); end end
module tb_top;
logic ref_clk, srst, read, write, waitrequest;
logic [5:0] address;
logic [31:0] writedata, readdata, rd;
logic [3:0] byteenable;
int n_fail = 0;
int tests_run = 0;
int cycles = 0;
effective_address_decoder DUT (.ref_clk(ref_clk), .srst(srst), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest));
initial
begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
end
////////////////////////////////////////////////////////////////////////////////
// The request is held until waitrequest is seen low; a hang is cut by the cycle ceiling.
task bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
begin
    @(posedge ref_clk);
    address <= a;
    writedata <= d;
    read <= ~wr;
    write <= wr;
    @(posedge ref_clk);
    while (waitrequest !== 1'b0) @(posedge ref_clk);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
end
endtask
function automatic logic [2:0] ea_cyc(input logic [4:0] c);
    if (c < 5'h08) return 3'h0;
    if (c < 5'h0C || (c >= 5'h10 && c < 5'h1C) || c == 5'h1F) return 3'h1;
    if (c < 5'h10) return 3'h4;
    return 3'h2;
endfunction
function automatic logic [1:0] ea_ext(input logic [4:0] c);
    if (c >= 5'h10 && c < 5'h18) return 2'h1;
    if ((c >= 5'h18 && c < 5'h1C) || c >= 5'h1E) return 2'h2;
    return 2'h0;
endfunction
function automatic logic [2:0] ea_base(input logic [4:0] c);
    if (c < 5'h08 || c >= 5'h1E) return 3'h0;
    if (c >= 5'h10 && c < 5'h18) return c[2:0];
    return {1'b0, c[1:0]};
endfunction
function automatic logic [2:0] cor(input int p, input logic odd, input int w);
    logic [2:0] slow [3] = '{3'h1, 3'h3, 3'h6};
    logic [2:0] even_out [3] = '{3'h1, 3'h1, 3'h2};
    if (p == 0 || (p == 1 && !odd)) return 3'h0;
    if (p == 1) return (w == 0) ? 3'h0 : 3'(w);
    if (p == 2 && !odd) return even_out[w];
    return slow[w];
endfunction
////////////////////////////////////////////////////////////////////////////////
task test_decode;
    logic [4:0] c;
    logic [1:0] w;
begin
    bus(1'b1, 6'h04, 32'h00000001);
    for (int i = 0; i < 32; i++)
    begin
        c = 5'(i);
        w = 2'(i % 3);
        bus(1'b1, 6'h00, {12'h000, 8'h03, 4'h2, 1'b1, w, c});
        bus(1'b0, 6'h08, 32'h00000000);
        `CHK("ea_cyc", ea_cyc(c), rd[8:6])
        `CHK("base_reg", ea_base(c), rd[5:3])
        `CHK("reg_sel", ((w == 2'h2) ? {1'b0, c[2:1]} : c[2:0]), rd[16:14])
        `CHK("width", w, rd[18:17])
        `CHK("is_reg", c < 5'h08, rd[13])
        `CHK("is_mem", c >= 5'h08, rd[12])
        `CHK("post_inc", c >= 5'h0C && c < 5'h10, rd[11])
        `CHK("ext", ea_ext(c), rd[10:9])
        `CHK("mode", {c == 5'h1C || c == 5'h1D, c == 5'h1E, c == 5'h1F}, rd[2:0])
        bus(1'b0, 6'h0C, 32'h00000000);
        `CHK("length", 5'h2 + 5'(ea_ext(c)), rd[4:0])
        `CHK("cycles", 10'h3 + 10'(ea_cyc(c)), rd[17:8])
    end
    $display("test_decode done");
end
endtask
task test_correction;
begin
    bus(1'b1, 6'h00, {12'h000, 8'h00, 4'h1, 1'b0, 2'h0, 5'h08});
    for (int p = 0; p < 4; p++)
        for (int o = 0; o < 2; o++)
            for (int w = 0; w < 3; w++)
            begin
                bus(1'b1, 6'h00, {12'h000, 8'h00, 4'h1, 1'b0, 2'(w), 5'h08});
                bus(1'b1, 6'h04, {29'h0, o[0], 2'(p)});
                bus(1'b0, 6'h0C, 32'h00000000);
                `CHK("fixed_len", 5'h1, rd[4:0])
                `CHK("corr", 10'h1 + 10'(cor(p, o[0], w)), rd[17:8])
            end
    $display("test_correction done");
end
endtask
task test_imm_vector;
    logic [7:0] v [3] = '{8'h80, 8'h7F, 8'hA5};
begin
    foreach (v[i])
    begin
        bus(1'b1, 6'h10, {24'h0, v[i]});
        bus(1'b0, 6'h10, 32'h00000000);
        `CHK("sext", {{8{v[i][7]}}, v[i]}, rd[31:16])
        bus(1'b0, 6'h14, 32'h00000000);
        `CHK("vec", {v[i], 4'h0, v[i][3:0]}, rd[15:0])
    end
    $display("test_imm_vector done");
end
endtask
task test_loads;
begin
    bus(1'b1, 6'h18, 32'h00000185);
    bus(1'b0, 6'h1C, 32'h00000000);
    `CHK("sx_lo", 16'hFF85, rd[15:0])
    bus(1'b0, 6'h18, 32'h00000000);
    `CHK("sx_nz", 2'h1, rd[1:0])
    bus(1'b1, 6'h18, 32'h00000200);
    bus(1'b0, 6'h20, 32'h00000000);
    `CHK("push_hi", 16'hFF85, rd[15:0])
    bus(1'b0, 6'h1C, 32'h00000000);
    `CHK("zx_lo", 16'h0000, rd[15:0])
    bus(1'b0, 6'h18, 32'h00000000);
    `CHK("zx_nz", 2'h2, rd[1:0])
    bus(1'b1, 6'h18, 32'h000000F0);
    bus(1'b0, 6'h1C, 32'h00000000);
    `CHK("zx_hi_byte", 16'h00F0, rd[15:0])
    bus(1'b0, 6'h18, 32'h00000000);
    `CHK("zx_n", 2'h1, rd[1:0])
    bus(1'b1, 6'h08, 32'hFFFFFFFF);
    bus(1'b1, 6'h3C, 32'hFFFFFFFF);
    bus(1'b0, 6'h3C, 32'h00000000);
    `CHK("unmapped", 32'h00000000, rd)
    $display("test_loads done");
end
endtask
task tally_and_finish;
begin
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
        $display("All tests passed");
    else
        $display("Some tests failed");
    $finish;
end
endtask
// The full run needs well under 2000 cycles, so 20000 leaves ample margin.
always @(posedge ref_clk)
begin
    cycles++;
    if (cycles == 20000)
    begin
        n_fail++;
        tally_and_finish;
    end
end
initial
begin
    srst = 1'b1;
    read = 1'b0;
    write = 1'b0;
    address = 6'h00;
    writedata = 32'h00000000;
    byteenable = 4'hF;
    repeat (5) @(posedge ref_clk);
    srst <= 1'b0;
    test_decode;
    test_correction;
    test_imm_vector;
    test_loads;
    tally_and_finish;
end
endmodule
`default_nettype wire
